// ==== logic/hub_config_register_bank.sv ====
// configuration register bank of the three-port hub
`include "hub_cfg_regs.svh"
`default_nettype none
module hub_config_register_bank
  import hub_cfg_pkg::*;
#(
  parameter int PORTS = 3
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire byte_t       reg_addr,
  input  wire byte_t       reg_wdata,
  output var  byte_t       reg_rdata,
  output var  logic        reg_rvalid,
  input  wire logic        config_done,
  input  wire logic        standby,
  input  wire logic        force_single_tt,
  input  wire logic [6:1]  remap_num,
  output var  logic        comm_stage,
  output var  logic        power_source_select,
  output var  logic        per_port_translator_on,
  output var  oc_sense_e   overcurrent_sense_style,
  output var  logic        power_switch_style,
  output var  logic        compound_device,
  output var  logic        port_renumber_mode,
  output var  logic        string_desc_on,
  output var  logic [3:1]  fixed_port_mask,
  output var  logic [3:1]  port_off_active,
  output var  logic [1:0]  enabled_port_count,
  output var  logic [6:1]  reported_port_num,
  output var  byte_t       upstream_draw_value
);
  localparam int NREG = 8;
  localparam byte_t RESV = 8'h00;
  byte_t regs [NREG];
  logic  wr_ok;
  hub_stage_e stage_q;
  hub_stage_e stage_d;
  logic       cm_d;
  // accesses only outside the communication stage
  assign wr_ok = reg_wr && (stage_q == STAGE_CONFIG);

  localparam byte_t RST [NREG] = '{`RST_CFG_ONE, `RST_CFG_TWO,
    `RST_CFG_THREE, `RST_FIXED_PORT, `RST_PORT_OFF_SP, `RST_PORT_OFF_BP,
    `RST_DRAW_SP, `RST_DRAW_BP};
  // reserved bits of port masks stay at default
  localparam byte_t WMSK [NREG] = '{8'hff, 8'hff, 8'hff, 8'h0e, 8'h0e,
    8'h0e, 8'hff, 8'hff};

  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    cfg_byte_reg #(
      .RESET_VALUE (RST[g]),
      .WRITE_MASK  (WMSK[g])
    ) u_reg (
      .clk     (clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .wr_en   (wr_ok && (reg_addr == 8'(`OFF_CFG_ONE + g))),
      .wr_data (reg_wdata),
      .value   (regs[g])
    );
  end

  // read path
  byte_t rdata_d;
  logic  rvalid_d;
  byte_t rdata_q;
  logic  rvalid_q;
  always_comb
  begin
    rdata_d  = RESV;
    rvalid_d = reg_rd && (stage_q == STAGE_CONFIG);
    if (reg_addr >= `OFF_CFG_ONE && reg_addr <= `OFF_DRAW_BP)
    begin
      rdata_d = regs[3'(reg_addr - `OFF_CFG_ONE)];
    end
  end

  always_comb
  begin
    stage_d = stage_q;
    unique case (stage_q)
      STAGE_CONFIG:
      begin
        if (config_done && !standby)
        begin
          stage_d = STAGE_COMM;
        end
      end
      STAGE_COMM:
      begin
        if (standby)
        begin
          stage_d = STAGE_CONFIG;
        end
      end
      default: stage_d = STAGE_CONFIG;
    endcase
  end
  assign cm_d = (stage_d == STAGE_COMM);

  // decoded live values
  byte_t c1;
  byte_t c2;
  byte_t c3;
  logic  self_pw;
  logic [3:1] off_live;
  logic [1:0] cnt_live;
  logic [6:1] num_live;
  oc_sense_e  oc_live;
  assign c1 = regs[0];
  assign c2 = regs[1];
  assign c3 = regs[2];
  assign self_pw = c1[`BIT_POWER_SRC];
  always_comb
  begin
    if (c1[`BIT_OC_HI])
      oc_live = SENSE_NONE;
    else if (c1[`BIT_OC_LO])
      oc_live = SENSE_PER_PORT;
    else
      oc_live = SENSE_GANGED;
  end
  assign off_live = self_pw
    ? regs[4][`PORT_BITS_HI:`PORT_BITS_LO]
    : regs[5][`PORT_BITS_HI:`PORT_BITS_LO];

  port_numbering #(
    .PORTS (PORTS)
  ) u_num (
    .port_off     (off_live),
    .active_count (cnt_live),
    .reported_num (num_live)
  );

  // frozen outputs
  logic       pw_q, tt_q, sw_q, cmp_q, map_q, str_q, cm_q;
  oc_sense_e  oc_q;
  logic [3:1] fix_q, off_q;
  logic [1:0] cnt_q;
  logic [6:1] num_q;
  byte_t      draw_q;
  logic       pw_d, tt_d, sw_d, cmp_d, map_d, str_d;
  oc_sense_e  oc_d;
  logic [3:1] fix_d, off_d;
  logic [1:0] cnt_d;
  logic [6:1] num_d;
  byte_t      draw_d;

  always_comb
  begin
    pw_d   = pw_q;
    tt_d   = tt_q;
    sw_d   = sw_q;
    cmp_d  = cmp_q;
    map_d  = map_q;
    str_d  = str_q;
    oc_d   = oc_q;
    fix_d  = fix_q;
    off_d  = off_q;
    cnt_d  = cnt_q;
    num_d  = num_q;
    draw_d = draw_q;
    // track until configuration ends, then hold
    if (stage_d == STAGE_CONFIG)
    begin
      pw_d  = self_pw;
      tt_d  = c1[`BIT_PER_PORT_TT] && !force_single_tt;
      oc_d  = oc_live;
      sw_d  = c1[`BIT_SWITCH_STYLE];
      cmp_d = c2[`BIT_COMPOUND];
      map_d = c3[`BIT_RENUMBER];
      str_d = c3[`BIT_STRING_EN];
      fix_d = regs[3][`PORT_BITS_HI:`PORT_BITS_LO];
      draw_d = self_pw ? regs[6] : regs[7];
      if (c3[`BIT_RENUMBER])
      begin
        off_d = {remap_num[6:5] == 2'h0, remap_num[4:3] == 2'h0,
                 remap_num[2:1] == 2'h0};
        cnt_d = 2'((remap_num[2:1] != 2'h0) + (remap_num[4:3] != 2'h0)
                   + (remap_num[6:5] != 2'h0));
        num_d = remap_num;
      end
      else
      begin
        off_d = off_live;
        cnt_d = cnt_live;
        num_d = num_live;
      end
    end
    else if (tt_q && force_single_tt)
    begin
      // in communication the host may drop to single translator, never back until standby
      tt_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stage_q <= STAGE_CONFIG;
      cm_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      stage_q <= stage_d;
      cm_q    <= cm_d;
    end
  end

  // read data refreshed every enabled cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pw_q   <= 1'b1;
      tt_q   <= 1'b1;
      sw_q   <= 1'b0;
      cmp_q  <= 1'b0;
      map_q  <= 1'b0;
      str_q  <= 1'b1;
      oc_q   <= SENSE_GANGED;
      fix_q  <= 3'h0;
      off_q  <= 3'h0;
      cnt_q  <= 2'h3;
      num_q  <= 6'h39;
      draw_q <= `RST_DRAW_SP;
    end
    else if (clk_en)
    begin
      pw_q   <= pw_d;
      tt_q   <= tt_d;
      sw_q   <= sw_d;
      cmp_q  <= cmp_d;
      map_q  <= map_d;
      str_q  <= str_d;
      oc_q   <= oc_d;
      fix_q  <= fix_d;
      off_q  <= off_d;
      cnt_q  <= cnt_d;
      num_q  <= num_d;
      draw_q <= draw_d;
    end
  end

  assign reg_rdata               = rdata_q;
  assign reg_rvalid              = rvalid_q;
  assign comm_stage              = cm_q;
  assign power_source_select     = pw_q;
  assign per_port_translator_on  = tt_q;
  assign overcurrent_sense_style = oc_q;
  assign power_switch_style      = sw_q;
  assign compound_device         = cmp_q;
  assign port_renumber_mode      = map_q;
  assign string_desc_on          = str_q;
  assign fixed_port_mask         = fix_q;
  assign port_off_active         = off_q;
  assign enabled_port_count      = cnt_q;
  assign reported_port_num       = num_q;
  assign upstream_draw_value     = draw_q;

  no_comm_write_a: assert property (@(posedge clk) disable iff (reset)
    (stage_q == STAGE_COMM && clk_en && reg_wr)
    |=> $stable({regs[0], regs[1], regs[2], regs[3],
                 regs[4], regs[5], regs[6], regs[7]}))
    else $error("config written in communication stage");
  frozen_cfg_a: assert property (@(posedge clk) disable iff (reset)
    (cm_q && stage_q == STAGE_COMM && !standby) |=> $stable(draw_q))
    else $error("draw value changed while frozen");
  force_single_a: assert property (@(posedge clk) disable iff (reset)
    (force_single_tt && clk_en) |=> !tt_q)
    else $error("translator not forced single");
  // power source follows register in config
  power_src_a: assert property (@(posedge clk) disable iff (reset)
    (stage_d == STAGE_CONFIG && clk_en) |=> pw_q == $past(self_pw))
    else $error("power source mismatch");
  draw_sel_a: assert property (@(posedge clk) disable iff (reset)
    (stage_d == STAGE_CONFIG && clk_en)
    |=> draw_q == ($past(self_pw) ? $past(regs[6]) : $past(regs[7])))
    else $error("wrong draw register reported");
  oc_none_a: assert property (@(posedge clk) disable iff (reset)
    (stage_d == STAGE_CONFIG && clk_en && c1[`BIT_OC_HI])
    |=> oc_q == SENSE_NONE)
    else $error("overcurrent decode wrong");
  port_count_a: assert property (@(posedge clk) disable iff (reset)
    (!map_q) |-> cnt_q == 2'(3 - $countones(off_q)))
    else $error("enabled port count wrong");
  resv_bits_a: assert property (@(posedge clk) disable iff (reset)
    regs[4][0] == 1'b0 && regs[5][7:4] == 4'h0)
    else $error("reserved port mask bit set");
  tt_follow_a: assert property (@(posedge clk) disable iff (reset)
    (stage_d == STAGE_CONFIG && clk_en)
    |=> tt_q == ($past(c1[`BIT_PER_PORT_TT]) && !$past(force_single_tt)))
    else $error("translator arrangement mismatch");
  remap_num_a: assert property (@(posedge clk) disable iff (reset)
    (stage_d == STAGE_CONFIG && clk_en && c3[`BIT_RENUMBER])
    |=> num_q == $past(remap_num))
    else $error("remapped port numbers not taken");
  string_en_a: assert property (@(posedge clk) disable iff (reset)
    (stage_d == STAGE_CONFIG && clk_en)
    |=> str_q == $past(c3[`BIT_STRING_EN]))
    else $error("string support flag mismatch");
  read_refused_a: assert property (@(posedge clk) disable iff (reset)
    (stage_q == STAGE_COMM && clk_en) |=> !reg_rvalid)
    else $error("read answered in communication stage");
  cfg_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!clk_en)
    |=> $stable({regs[0], regs[1], regs[2], regs[3],
                 regs[4], regs[5], regs[6], regs[7]}) && $stable(stage_q))
    else $error("state changed with clock enable low");
endmodule : hub_config_register_bank
`default_nettype wire

// ==== logic/hub_cfg_regs.svh ====
// register offsets, reset values and field positions of the hub config bank
// Overview of operation
// - bit 7 byte one: bus or self power
// - bit 4 byte one: shared or per-port translators
// - host may force shared translator only
// - bits 2:1 byte one: overcurrent sensing style
// - bit 0 byte one: grouped or individual switching
// - bit 3 byte two: compound device flag
// - standard mode: disable masks, contiguous renumbering
// - renumber mode: numbering from remap_num input
// - bit 0 byte three: string descriptor enable
// - fixed port mask bits 3:1 flag ports
// - self-powered mask bits 3:1 disable ports
// - bus-powered mask bits disable ports while bus powered
// - any combination; report count, reorder ports
// - self-powered draw in 2 mA units
// - bus-powered draw, reset 0xfa is 500 mA
// - draw values include embedded peripheral consumption
// - reset values 0x98, 0x20, 0x03, 0x01
// - unwritten registers keep reset defaults
// - no access in communication stage until standby
`ifndef HUB_CFG_REGS_SVH
`define HUB_CFG_REGS_SVH
`define OFF_CFG_ONE      8'h06
`define OFF_CFG_TWO      8'h07
`define OFF_CFG_THREE    8'h08
`define OFF_FIXED_PORT   8'h09
`define OFF_PORT_OFF_SP  8'h0a
`define OFF_PORT_OFF_BP  8'h0b
`define OFF_DRAW_SP      8'h0c
`define OFF_DRAW_BP      8'h0d
`define RST_CFG_ONE      8'h98
`define RST_CFG_TWO      8'h20
`define RST_CFG_THREE    8'h03
`define RST_FIXED_PORT   8'h00
`define RST_PORT_OFF_SP  8'h00
`define RST_PORT_OFF_BP  8'h00
`define RST_DRAW_SP      8'h01
`define RST_DRAW_BP      8'hfa
`define BIT_POWER_SRC    7
`define BIT_PER_PORT_TT  4
`define BIT_OC_HI        2
`define BIT_OC_LO        1
`define BIT_SWITCH_STYLE 0
`define BIT_COMPOUND     3
`define BIT_RENUMBER     3
`define BIT_STRING_EN    0
`define PORT_BITS_HI     3
`define PORT_BITS_LO     1
`endif

// ==== logic/hub_cfg_pkg.sv ====
// types shared by the hub configuration bank
`default_nettype none
package hub_cfg_pkg;
  typedef enum logic [1:0] {
    SENSE_GANGED,
    SENSE_PER_PORT,
    SENSE_NONE
  } oc_sense_e;
  typedef enum logic [1:0] {
    STAGE_CONFIG,
    STAGE_COMM
  } hub_stage_e;
  typedef logic [7:0] byte_t;
endpackage : hub_cfg_pkg
`default_nettype wire

// ==== logic/cfg_byte_reg.sv ====
// one byte-wide configuration register with write-preserve behaviour
`default_nettype none
module cfg_byte_reg
  import hub_cfg_pkg::*;
#(
  parameter byte_t RESET_VALUE = 8'h00,
  parameter byte_t WRITE_MASK  = 8'hff
)(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  clk_en,
  input  wire logic  wr_en,
  input  wire byte_t wr_data,
  output var  byte_t value
);
  byte_t value_q;
  byte_t value_d;
  always_comb
  begin
    value_d = value_q;
    if (wr_en)
    begin
      value_d = (wr_data & WRITE_MASK) | (value_q & ~WRITE_MASK);
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      value_q <= RESET_VALUE;
    end
    else if (clk_en)
    begin
      value_q <= value_d;
    end
  end
  assign value = value_q;
endmodule : cfg_byte_reg
`default_nettype wire

// ==== logic/port_numbering.sv ====
// maps enabled physical ports to contiguous reported numbers
`default_nettype none
module port_numbering
  import hub_cfg_pkg::*;
#(
  parameter int PORTS = 3
)(
  input  wire logic [PORTS:1]   port_off,
  output var  logic [1:0]       active_count,
  output var  logic [PORTS*2:1] reported_num
);
  always_comb
  begin
    logic [1:0] n;
    n = 2'h0;
    reported_num = '0;
    for (int p = 1; p <= PORTS; p++)
    begin
      if (!port_off[p])
      begin
        n = 2'(n + 2'h1);
        reported_num[p*2 -: 2] = n;
      end
    end
    active_count = n;
  end
endmodule : port_numbering
`default_nettype wire

// ==== verification/cfg_host_model.sv ====
// host model on the byte-wide register port of the hub bank
`default_nettype none
module cfg_host_model
  import hub_cfg_pkg::*;
(
  input  wire logic  clk,
  input  wire byte_t reg_rdata,
  input  wire logic  reg_rvalid,
  output var  logic  reg_wr,
  output var  logic  reg_rd,
  output var  byte_t reg_addr,
  output var  byte_t reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // legal values only
  // callers pick bus power before no-sensing and keep draws small
  task automatic wr(input byte_t a, input byte_t d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    // idle edge so a following request never lands in this step
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input byte_t a, output byte_t d, output logic ok);
    int i;
    reg_addr = a;
    reg_rd   = 1'b1;
    ok       = 1'b0;
    d        = 8'h00;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    for (i = 0; i < 3 && !ok; i++)
    begin
      if (reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d  = reg_rdata;
      end
      @(posedge clk);
      #1;
    end
  endtask : rd
endmodule : cfg_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the hub configuration register bank
`default_nettype none
module tb_top
  import hub_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       config_done = 1'b0;
  logic       standby = 1'b0;
  logic       force_single_tt = 1'b0;
  logic       clk_en = 1'b1;
  logic [6:1] remap_num = 6'h00;
  logic       reg_wr, reg_rd, reg_rvalid, comm_stage, pw, tt, sw;
  logic       cmp, rnm, str;
  byte_t      reg_addr, reg_wdata, reg_rdata, draw;
  oc_sense_e  oc;
  logic [3:1] fpm, poa;
  logic [1:0] cnt;
  logic [6:1] num;
  int         error_cnt = 0;
  int         check_count = 0;
  byte_t      rst_val [8] = '{8'h98, 8'h20, 8'h03, 8'h00,
                              8'h00, 8'h00, 8'h01, 8'hfa};
  always #5 clk = ~clk;
  cfg_host_model host (.clk(clk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  hub_config_register_bank DUT (.clk(clk), .reset(reset), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .config_done(config_done), .standby(standby),
    .force_single_tt(force_single_tt), .remap_num(remap_num),
    .comm_stage(comm_stage), .power_source_select(pw),
    .per_port_translator_on(tt), .overcurrent_sense_style(oc),
    .power_switch_style(sw), .compound_device(cmp),
    .port_renumber_mode(rnm), .string_desc_on(str),
    .fixed_port_mask(fpm), .port_off_active(poa),
    .enabled_port_count(cnt), .reported_port_num(num),
    .upstream_draw_value(draw));
  task automatic chk(input string n, input byte_t seen, input byte_t exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input byte_t a, input byte_t exp);
    byte_t d;
    logic  ok;
    host.rd(a, d, ok);
    chk("rvalid", {7'h00, ok}, 8'h01);
    chk("rdata", d, exp);
  endtask : rdchk
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    #200000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    byte_t d;
    logic  ok;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    chk("pw", {7'h00, pw}, 8'h01);
    chk("tt", {7'h00, tt}, 8'h01);
    chk("sw", {7'h00, sw}, 8'h00);
    chk("str", {7'h00, str}, 8'h01);
    chk("cnt", {6'h00, cnt}, 8'h03);
    chk("num", {2'h0, num}, 8'h39);
    chk("draw", draw, 8'h01);
    for (int i = 0; i < 8; i++)
      rdchk(8'h06 + 8'(i), rst_val[i]);
    rdchk(8'h05, 8'h00);
    host.wr(8'h06, 8'h1f);
    settle();
    chk("pw", {7'h00, pw}, 8'h00);
    chk("oc", {6'h00, oc}, 8'h02);
    chk("sw", {7'h00, sw}, 8'h01);
    chk("draw", draw, 8'hfa);
    force_single_tt = 1'b1;
    settle();
    chk("tt", {7'h00, tt}, 8'h00);
    force_single_tt = 1'b0;
    host.wr(8'h0b, 8'h04);
    host.wr(8'h0a, 8'h02);
    host.wr(8'h09, 8'h0e);
    settle();
    chk("poa", {5'h00, poa}, 8'h02);
    chk("cnt", {6'h00, cnt}, 8'h02);
    chk("num", {2'h0, num}, 8'h21);
    chk("fpm", {5'h00, fpm}, 8'h07);
    rdchk(8'h09, 8'h0e);
    rdchk(8'h0a, 8'h02);
    host.wr(8'h06, 8'h88);
    host.wr(8'h0c, 8'h04);
    settle();
    chk("oc", {6'h00, oc}, 8'h00);
    chk("tt", {7'h00, tt}, 8'h00);
    chk("poa", {5'h00, poa}, 8'h01);
    chk("num", {2'h0, num}, 8'h24);
    chk("draw", draw, 8'h04);
    host.wr(8'h06, 8'h8a);
    settle();
    chk("oc", {6'h00, oc}, 8'h01);
    host.wr(8'h09, 8'h02);
    host.wr(8'h07, 8'h28);
    remap_num = 6'h1b;
    host.wr(8'h08, 8'h0a);
    settle();
    chk("cmp", {7'h00, cmp}, 8'h01);
    chk("rnm", {7'h00, rnm}, 8'h01);
    chk("str", {7'h00, str}, 8'h00);
    chk("num", {2'h0, num}, 8'h1b);
    clk_en = 1'b0;
    host.wr(8'h0d, 8'h10);
    clk_en = 1'b1;
    rdchk(8'h0d, 8'hfa);
    config_done = 1'b1;
    settle();
    chk("comm", {7'h00, comm_stage}, 8'h01);
    remap_num = 6'h39;
    host.wr(8'h08, 8'h03);
    host.rd(8'h08, d, ok);
    chk("rvalid", {7'h00, ok}, 8'h00);
    chk("num", {2'h0, num}, 8'h1b);
    chk("str", {7'h00, str}, 8'h00);
    standby = 1'b1;
    config_done = 1'b0;
    settle();
    chk("comm", {7'h00, comm_stage}, 8'h00);
    chk("num", {2'h0, num}, 8'h39);
    standby = 1'b0;
    rdchk(8'h08, 8'h0a);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
